// ---- rtl/sfp_flash_guard.sv ----
/*
 * Serial flash write-protect decode and instruction framing.
 * Assumes: host drives chip select, serial clock and serial data in mode 0/3;
 * the serial clock stands still while chip select is high, and chip select
 * stays high for at least four system clocks between frames.
 */
`timescale 1ns/1ps

module sfp_flash_guard #(
    parameter logic [15:0] BUSY_CYCLES = 16'h0010,
    parameter logic [7:0] MAKER_ID = 8'h5A,     // Arbitrary value
    parameter logic [7:0] DEV_ID8 = 8'h3C,      // Arbitrary value
    parameter logic [15:0] DEV_ID16 = 16'hA1C3  // Arbitrary value
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic spi_clk_i,
    input wire logic cs_n_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    input wire logic protect_scheme_sel_i,
    input wire logic range_invert_i,
    input wire logic granularity_sel_i,
    input wire logic top_bottom_sel_i,
    input wire logic range_code_bit2_i,
    input wire logic range_code_bit1_i,
    input wire logic range_code_bit0_i,
    output logic busy_o,
    output logic cmd_valid_o,
    output logic [7:0] cmd_op_o,
    output logic [23:0] cmd_lo_o,
    output logic [23:0] cmd_hi_o,
    output logic cmd_reject_o,
    output logic cmd_drop_o
);
    import sfp_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Two closed ranges share an address
    function automatic logic overlap(input logic [23:0] alo, input logic [23:0] ahi,
                                     input logic [23:0] blo, input logic [23:0] bhi);
        overlap = (alo <= bhi) && (blo <= ahi);
    endfunction

    // Protected range for the complemented decode: {valid, lo, hi}
    function automatic logic [48:0] range_bounds(input logic sec, input logic tb,
                                                 input logic [2:0] bp);
        logic [23:0] sz;
        logic v;
        sz = '0;
        v = 1'b1;
        if (bp == 3'b111) begin
            v = 1'b0;
        end else if (bp == 3'b000) begin
            sz = '0;
        end else if (!sec) begin
            sz = LARGE_UNIT << (bp - 3'd1);
        end else if (bp[2]) begin
            sz = SMALL_MAX;
        end else begin
            sz = SMALL_UNIT << (bp - 3'd1);
        end
        range_bounds = {v, (tb ? sz : ARRAY_BASE), (tb ? ARRAY_TOP : ARRAY_TOP - sz)};
    endfunction

    // Base address of one lock unit
    function automatic logic [23:0] unit_lo(input int i);
        if (i < LOCK_MID0) begin
            unit_lo = 24'(i) << SEC_SHIFT;
        end else if (i < LOCK_TOP0) begin
            unit_lo = 24'(i - LOCK_MID0 + 1) << BLK_SHIFT;
        end else begin
            unit_lo = TOP_BLK_BASE + (24'(i - LOCK_TOP0) << SEC_SHIFT);
        end
    endfunction

    // Lock unit index for an address
    function automatic logic [7:0] unit_idx(input logic [23:0] a);
        if (a[23:16] == 8'h00) begin
            unit_idx = {4'h0, a[15:12]};
        end else if (a[23:16] >= TOP_BLK_BASE[23:16]) begin
            unit_idx = LOCK_TOP_OFS + {4'h0, a[15:12]};
        end else begin
            unit_idx = LOCK_MID_OFS + a[23:16];
        end
    endfunction

    // Answer byte for reads: {enable, byte}
    function automatic logic [8:0] answer(input logic [7:0] op, input logic [7:0] idx,
                                          input logic busy);
        answer = '0;
        case (op)
            OP_STAT_RD: answer = {1'b1, 7'h00, busy};
            OP_ID_LEGACY: begin
                if (idx >= ID_FIRST) begin
                    answer = {!busy, DEV_ID8};
                end
            end
            OP_ID_MAKER: begin
                if (idx >= ID_FIRST) begin
                    answer = {!busy, (idx[0] ? DEV_ID8 : MAKER_ID)};
                end
            end
            OP_ID_STD: begin
                if (idx == STD_MAKER) begin
                    answer = {!busy, MAKER_ID};
                end else if (idx == STD_HI) begin
                    answer = {!busy, DEV_ID16[15:8]};
                end else if (idx == STD_LO) begin
                    answer = {!busy, DEV_ID16[7:0]};
                end
            end
            default: answer = '0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Link side: frame start flag, set while chip select is high
    // ------------------------------------------------------------------
    sfp_sys_t s_q, s_d;
    sfp_lrx_t l_q, l_d;
    sfp_ltx_t t_q, t_d;
    logic frame_q;

    // Set asynchronously by chip select high, cleared by the first bit
    always_ff @(posedge spi_clk_i or posedge cs_n_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_q <= 1'b1;
        end else if (cs_n_i) begin
            frame_q <= 1'b1;
        end else begin
            frame_q <= 1'b0;
        end
    end

    // Bit shifter, opcode and address capture
    always_comb begin
        logic [2:0] base_idx;
        logic [7:0] base_cnt;
        logic [7:0] b;
        base_idx = frame_q ? 3'h0 : l_q.bit_idx;
        base_cnt = frame_q ? 8'h00 : l_q.byte_cnt;
        b = {l_q.sh, serial_in_i};
        l_d = l_q;
        l_d.sh = frame_q ? {6'h00, serial_in_i} : b[6:0];
        l_d.bit_idx = base_idx + 3'd1;
        l_d.byte_cnt = base_cnt;
        l_d.busy_sync = {l_q.busy_sync[0], s_q.busy};
        if (base_idx == LAST_BIT) begin
            l_d.byte_cnt = (base_cnt == CNT_MAX) ? CNT_MAX : base_cnt + 8'd1;
            if (base_cnt == 8'h00) begin
                l_d.op = b;
            end else if (base_cnt < LEN_ADDR) begin
                l_d.addr = {l_q.addr[15:0], b};
            end
        end
    end

    always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // Answer shifter on the falling serial clock
    always_comb begin
        logic [8:0] ans;
        ans = answer(l_q.op, l_q.byte_cnt, l_q.busy_sync[1]);
        t_d = t_q;
        // Released through the opcode byte, so no enable lingers from the last frame
        if (frame_q || l_q.byte_cnt == 8'h00) begin
            t_d.oe = 1'b0;
        end else if (l_q.bit_idx == 3'h0 && l_q.byte_cnt != 8'h00) begin
            t_d.out_sh = ans[7:0];
            t_d.oe = ans[8];
        end else begin
            t_d.out_sh = {t_q.out_sh[6:0], 1'b0};
        end
    end

    always_ff @(negedge spi_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign serial_out_o = t_q.out_sh[7];
    assign serial_out_oe_o = t_q.oe & ~cs_n_i;

    // ------------------------------------------------------------------
    // System side: frame end, protection check, locks, busy
    // ------------------------------------------------------------------
    logic end_ev, aligned, range_op, len_ok, wr_op, wr_ok, range_hit, lock_hit;
    logic [2:0] bp;
    logic [48:0] bounds;
    logic [23:0] reg_lo, reg_hi;

    assign bp = {range_code_bit2_i, range_code_bit1_i, range_code_bit0_i};
    assign bounds = range_bounds(granularity_sel_i, top_bottom_sel_i, bp);
    // Chip select rise seen after two flops; link registers are still then
    assign end_ev = s_q.cs_sync[1] & ~s_q.cs_prev & (l_q.byte_cnt != 8'h00);
    assign aligned = (l_q.bit_idx == 3'h0);

    // Region and length check per opcode
    always_comb begin
        reg_lo = l_q.addr;
        reg_hi = l_q.addr;
        range_op = 1'b1;
        wr_op = 1'b1;
        len_ok = (l_q.byte_cnt >= LEN_ADDR);
        case (l_q.op)
            OP_PROG: begin
                reg_lo = l_q.addr & ~PAGE_MASK;
                reg_hi = l_q.addr | PAGE_MASK;
                len_ok = (l_q.byte_cnt >= LEN_PROG);
            end
            OP_SEC_ERASE: begin
                reg_lo = l_q.addr & ~SEC_MASK;
                reg_hi = l_q.addr | SEC_MASK;
            end
            OP_BLK32_ERASE: begin
                reg_lo = l_q.addr & ~BLK32_MASK;
                reg_hi = l_q.addr | BLK32_MASK;
            end
            OP_BLK64_ERASE: begin
                reg_lo = l_q.addr & ~BLK64_MASK;
                reg_hi = l_q.addr | BLK64_MASK;
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                reg_lo = ARRAY_BASE;
                reg_hi = ARRAY_TOP;
                len_ok = 1'b1;
            end
            OP_STAT_WR1, OP_STAT_WR2, OP_STAT_WR3: begin
                range_op = 1'b0;
                len_ok = (l_q.byte_cnt >= LEN_STAT);
            end
            OP_LOCK_ALL, OP_UNLOCK_ALL: begin
                range_op = 1'b0;
                len_ok = 1'b1;
            end
            OP_LOCK_ONE, OP_UNLOCK_ONE: range_op = 1'b0;
            default: begin
                range_op = 1'b0;
                wr_op = 1'b0;
            end
        endcase
    end

    assign wr_ok = end_ev & wr_op & aligned & len_ok & ~s_q.busy;

    // Range decode and lock scan over full 24-bit bounds
    always_comb begin
        lock_hit = 1'b0;
        for (int i = 0; i < N_LOCK; i++) begin
            if (s_q.lock[i] && overlap(reg_lo, reg_hi, unit_lo(i),
                                       unit_lo(i) | ((i < LOCK_MID0 || i >= LOCK_TOP0)
                                                     ? SEC_MASK : BLK64_MASK))) begin
                lock_hit = 1'b1;
            end
        end
        if (range_invert_i) begin
            range_hit = bounds[48] & overlap(reg_lo, reg_hi, bounds[47:24], bounds[23:0]);
        end else begin
            range_hit = ~bounds[48] | (reg_lo < bounds[47:24]) | (reg_hi > bounds[23:0]);
        end
    end

    // Next system state
    always_comb begin
        s_d = s_q;
        s_d.cs_sync = {s_q.cs_sync[0], cs_n_i};
        s_d.cs_prev = s_q.cs_sync[1];
        s_d.cmd_valid = 1'b0;
        s_d.reject = 1'b0;
        s_d.drop = 1'b0;
        // Busy countdown
        if (s_q.busy_cnt != 16'h0000) begin
            s_d.busy_cnt = s_q.busy_cnt - 16'd1;
        end
        s_d.busy = (s_d.busy_cnt != 16'h0000);
        if (end_ev && wr_op && !wr_ok) begin
            s_d.drop = 1'b1;
        end else if (wr_ok) begin
            if (range_op && (protect_scheme_sel_i ? lock_hit : range_hit)) begin
                s_d.reject = 1'b1;
            end else if (l_q.op == OP_LOCK_ALL) begin
                s_d.lock = '1;
            end else if (l_q.op == OP_UNLOCK_ALL) begin
                s_d.lock = '0;
            end else if (l_q.op == OP_LOCK_ONE || l_q.op == OP_UNLOCK_ONE) begin
                if (unit_idx(l_q.addr) < 8'(N_LOCK)) begin
                    s_d.lock[unit_idx(l_q.addr)] = (l_q.op == OP_LOCK_ONE);
                end
            end else begin
                s_d.cmd_valid = 1'b1;
                s_d.cmd_op = l_q.op;
                s_d.cmd_lo = reg_lo;
                s_d.cmd_hi = reg_hi;
                s_d.busy_cnt = BUSY_CYCLES;
                s_d.busy = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.cs_sync <= 2'b11;
            s_q.cs_prev <= 1'b1;
            s_q.lock <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = s_q.busy;
    assign cmd_valid_o = s_q.cmd_valid;
    assign cmd_op_o = s_q.cmd_op;
    assign cmd_lo_o = s_q.cmd_lo;
    assign cmd_hi_o = s_q.cmd_hi;
    assign cmd_reject_o = s_q.reject;
    assign cmd_drop_o = s_q.drop;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic scheme0_cmp;
    assign scheme0_cmp = wr_ok & range_op & ~protect_scheme_sel_i & range_invert_i;

    property p_all_prot;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (scheme0_cmp && bp == 3'b000) |=> cmd_reject_o && !cmd_valid_o;
    endproperty
    a_all_prot: assert property (p_all_prot) else $error("code 000 not fully protected");

    property p_none_prot;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (scheme0_cmp && bp == 3'b111) |=> cmd_valid_o ##1 busy_o;
    endproperty
    a_none_prot: assert property (p_none_prot) else $error("code 111 still protects");

    property p_low_half;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (scheme0_cmp && !granularity_sel_i && !top_bottom_sel_i && bp == 3'b110
         && reg_lo >= HALF_MARK) |=> cmd_valid_o;
    endproperty
    a_low_half: assert property (p_low_half) else $error("upper half wrongly protected");

    property p_up_63;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (scheme0_cmp && !granularity_sel_i && top_bottom_sel_i && bp == 3'b001
         && reg_hi < LARGE_UNIT) |=> cmd_valid_o && cmd_hi_o < LARGE_UNIT;
    endproperty
    a_up_63: assert property (p_up_63) else $error("lowest 128KB wrongly protected");

    property p_fine_top;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (scheme0_cmp && granularity_sel_i && !top_bottom_sel_i && bp[2:1] == 2'b10
         && reg_lo >= ARRAY_TOP - BLK32_MASK) |=> cmd_valid_o;
    endproperty
    a_fine_top: assert property (p_fine_top) else $error("top 32KB wrongly protected");

    property p_fine_bot;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (scheme0_cmp && granularity_sel_i && top_bottom_sel_i && bp == 3'b001
         && reg_lo >= SMALL_UNIT) |=> cmd_reject_o;
    endproperty
    a_fine_bot: assert property (p_fine_bot) else $error("area above 4KB not protected");

    property p_reject_quiet;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(cmd_reject_o) && !$past(busy_o) |-> !cmd_valid_o && !busy_o;
    endproperty
    a_reject_quiet: assert property (p_reject_quiet) else $error("rejected command acted");

    property p_lock_scheme;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (wr_ok && range_op && protect_scheme_sel_i && s_q.lock == '0) |=> cmd_valid_o;
    endproperty
    a_lock_scheme: assert property (p_lock_scheme) else $error("unlocked region refused");

    property p_unaligned;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (end_ev && wr_op && !aligned) |=> cmd_drop_o && !cmd_valid_o && !cmd_reject_o;
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("partial byte write accepted");

    property p_busy_ignore;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (end_ev && busy_o) |=> !cmd_valid_o ##1 !cmd_valid_o;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

endmodule

// ---- include/sfp_pkg.sv ----
/*
 * Constants and state types for the serial flash write-protect and framing block.
 * Assumes an 8 MB array addressed with 24 bits and single-bit serial framing.
 */
package sfp_pkg;

    // ------------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------------
    localparam logic [23:0] ARRAY_TOP = 24'h7F_FFFF;
    localparam logic [23:0] ARRAY_BASE = 24'h00_0000;
    localparam logic [23:0] LARGE_UNIT = 24'h02_0000; // 128 KB step, coarse ranges
    localparam logic [23:0] SMALL_UNIT = 24'h00_1000; // 4 KB step, fine ranges
    localparam logic [23:0] SMALL_MAX = 24'h00_8000; // 32 KB, fine codes 100 to 110
    localparam logic [23:0] PAGE_MASK = 24'h00_00FF;
    localparam logic [23:0] SEC_MASK = 24'h00_0FFF;
    localparam logic [23:0] BLK32_MASK = 24'h00_7FFF;
    localparam logic [23:0] BLK64_MASK = 24'h00_FFFF;
    localparam logic [23:0] TOP_BLK_BASE = 24'h7F_0000;
    localparam logic [23:0] HALF_MARK = 24'h40_0000;
    localparam int SEC_SHIFT = 12;
    localparam int BLK_SHIFT = 16;

    // Lock units: 16 sectors, 126 middle blocks, 16 sectors
    localparam int N_LOCK = 158;
    localparam int LOCK_MID0 = 16;
    localparam int LOCK_TOP0 = 142;
    localparam logic [7:0] LOCK_MID_OFS = 8'h0F;
    localparam logic [7:0] LOCK_TOP_OFS = 8'h8E;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_SEC_ERASE = 8'h20;
    localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR1 = 8'h01;
    localparam logic [7:0] OP_STAT_WR2 = 8'h31;
    localparam logic [7:0] OP_STAT_WR3 = 8'h11;
    localparam logic [7:0] OP_ID_LEGACY = 8'hAB;
    localparam logic [7:0] OP_ID_MAKER = 8'h90;
    localparam logic [7:0] OP_ID_STD = 8'h9F;
    localparam logic [7:0] OP_LOCK_ALL = 8'h7E;
    localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
    localparam logic [7:0] OP_LOCK_ONE = 8'h36;
    localparam logic [7:0] OP_UNLOCK_ONE = 8'h39;

    // ------------------------------------------------------------------
    // Frame lengths in bytes, opcode included, and answer positions
    // ------------------------------------------------------------------
    localparam logic [7:0] LEN_OP = 8'h01;
    localparam logic [7:0] LEN_STAT = 8'h02;
    localparam logic [7:0] LEN_ADDR = 8'h04;
    localparam logic [7:0] LEN_PROG = 8'h05;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] ID_FIRST = 8'h04;   // first answer byte of AB/90
    localparam logic [7:0] STD_MAKER = 8'h01;
    localparam logic [7:0] STD_HI = 8'h02;
    localparam logic [7:0] STD_LO = 8'h03;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] cs_sync;
        logic cs_prev;
        logic [15:0] busy_cnt;
        logic busy;
        logic [N_LOCK-1:0] lock;
        logic cmd_valid;
        logic [7:0] cmd_op;
        logic [23:0] cmd_lo;
        logic [23:0] cmd_hi;
        logic reject;
        logic drop;
    } sfp_sys_t;

    typedef struct packed {
        logic [6:0] sh;
        logic [2:0] bit_idx;
        logic [7:0] byte_cnt;
        logic [7:0] op;
        logic [23:0] addr;
        logic [1:0] busy_sync;
    } sfp_lrx_t;

    typedef struct packed {
        logic [7:0] out_sh;
        logic oe;
    } sfp_ltx_t;

endpackage

// ---- sim/sfp_host_model.sv ----
/*
 * Host serial controller model: drives select, serial clock and data in.
 * Assumes the device samples data on the rising clock and answers on the falling.
 */
`timescale 1ns/1ps
module sfp_host_model (
    output logic spi_clk_o,
    output logic cs_n_o,
    output logic serial_in_o,
    input wire logic serial_out_i,
    input wire logic serial_out_oe_i
);
    // ----------------------------------------
    // Idle levels, clock stands still low
    // ----------------------------------------
    initial begin
        spi_clk_o = 1'b0;
        cs_n_o = 1'b1;
        serial_in_o = 1'b0;
    end

    // One frame, right-aligned bits sent MSB first, 30 ns clock
    task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
        rx = '0;
        cs_n_o = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_in_o = tx[i];
            #15 spi_clk_o = 1'b1;
            rx = {rx[62:0], (serial_out_oe_i ? serial_out_i : ~serial_out_i)}; // Undriven line
            #15 spi_clk_o = 1'b0;
        end
        #15 cs_n_o = 1'b1;
        serial_in_o = ~serial_in_o; // Released line shows no stale bit
        #500; // Select high well beyond 400 ns
    endtask
endmodule

// ---- sim/serial_flash_write_protect_and_framing_tb_top.sv ----
/*
 * Self-checking bench for the write-protect and framing block.
 * Assumes the host model drives the serial side and the bench the settings.
 */
`timescale 1ns/1ps
module serial_flash_write_protect_and_framing_tb_top;
    import sfp_pkg::*;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, spi_clk_i, cs_n_i, serial_in_i;
    logic serial_out_o, serial_out_oe_o, busy_o, cmd_valid_o, cmd_reject_o, cmd_drop_o;
    logic [7:0] cmd_op_o;
    logic [23:0] cmd_lo_o, cmd_hi_o;
    logic [6:0] prot = '0; // scheme, invert, granularity, top/bottom, code
    logic sv = 1'b0, sr = 1'b0, sd = 1'b0;
    logic [63:0] rx;
    int error_cnt = 0, compares = 0;
    // op, granularity, top/bottom, code, address, accepted
    localparam logic [37:0] TBL [13] = '{
        {8'h20, 5'b1_1000, 24'h7F_F000, 1'b0}, {8'h20, 5'b1_1111, 24'h00_0000, 1'b1},
        {8'h20, 5'b0_0001, 24'h7E_0000, 1'b1}, {8'h02, 5'b0_0001, 24'h7D_FF00, 1'b0},
        {8'h20, 5'b0_0110, 24'h40_0000, 1'b1}, {8'h20, 5'b0_0110, 24'h3F_F000, 1'b0},
        {8'h20, 5'b0_1001, 24'h01_F000, 1'b1}, {8'h20, 5'b0_1001, 24'h02_0000, 1'b0},
        {8'h20, 5'b1_0001, 24'h7F_F000, 1'b1}, {8'h20, 5'b1_0101, 24'h7F_7000, 1'b0},
        {8'h02, 5'b1_0101, 24'h7F_8000, 1'b1}, {8'h20, 5'b1_1011, 24'h00_3000, 1'b1},
        {8'h20, 5'b1_1011, 24'h00_4000, 1'b0}};

    always #50 clk_sys_i = ~clk_sys_i;

    sfp_flash_guard #(.BUSY_CYCLES(16'h0040), .MAKER_ID(8'h6B), .DEV_ID8(8'h47),
        .DEV_ID16(16'h1D2E)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .spi_clk_i(spi_clk_i), .cs_n_i(cs_n_i), .serial_in_i(serial_in_i),
        .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
        .protect_scheme_sel_i(prot[6]), .range_invert_i(prot[5]),
        .granularity_sel_i(prot[4]), .top_bottom_sel_i(prot[3]),
        .range_code_bit2_i(prot[2]), .range_code_bit1_i(prot[1]),
        .range_code_bit0_i(prot[0]), .busy_o(busy_o), .cmd_valid_o(cmd_valid_o),
        .cmd_op_o(cmd_op_o), .cmd_lo_o(cmd_lo_o), .cmd_hi_o(cmd_hi_o),
        .cmd_reject_o(cmd_reject_o), .cmd_drop_o(cmd_drop_o));

    sfp_host_model u_host (.spi_clk_o(spi_clk_i), .cs_n_o(cs_n_i),
        .serial_in_o(serial_in_i), .serial_out_i(serial_out_o),
        .serial_out_oe_i(serial_out_oe_o));

    // Sticky record of the one-cycle result pulses
    always @(posedge clk_sys_i) begin
        if (cmd_valid_o === 1'b1) sv <= 1'b1;
        if (cmd_reject_o === 1'b1) sr <= 1'b1;
        if (cmd_drop_o === 1'b1) sd <= 1'b1;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic set_prot(input logic [6:0] p);
        @(posedge clk_sys_i);
        #1 prot = p;
    endtask

    task automatic frame(input logic [63:0] tx, input int n);
        {sv, sr, sd} = 3'b000;
        u_host.xfer(tx, n, rx);
        repeat (6) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic idle();
        for (int k = 0; k < 200 && busy_o !== 1'b0; k++) @(posedge clk_sys_i);
        #1;
    endtask

    // Erase or program, judged as accepted or rejected
    task automatic wr(input logic [7:0] op, input logic [23:0] a, input logic ok);
        logic [23:0] m;
        m = (op == OP_PROG) ? PAGE_MASK : SEC_MASK;
        if (op == OP_PROG) frame({op, a, 8'hA5}, 40);
        else frame({op, a}, 32);
        chk("accepted", sv, ok);
        chk("rejected", sr, !ok);
        if (ok) begin
            chk("region", {cmd_lo_o, cmd_hi_o}, {a & ~m, a | m});
            chk("opcode", cmd_op_o, op);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_locks();
        chk("reset", {busy_o, cmd_valid_o, cmd_reject_o, cmd_drop_o, serial_out_oe_o}, 0);
        set_prot(7'b110_0111);
        wr(OP_SEC_ERASE, 24'h10_0000, 1'b0);
        frame(OP_UNLOCK_ALL, 8);
        wr(OP_SEC_ERASE, 24'h10_0000, 1'b1);
        idle();
        set_prot(7'b010_0000);
        wr(OP_SEC_ERASE, 24'h10_0000, 1'b0);
        frame(OP_LOCK_ALL, 8);
        set_prot(7'b010_0111);
        wr(OP_SEC_ERASE, 24'h10_0000, 1'b1);
        idle();
        set_prot(7'b110_0111);
        frame({OP_UNLOCK_ONE, 24'h10_0000}, 32);
        wr(OP_SEC_ERASE, 24'h10_F000, 1'b1);
        idle();
        wr(OP_SEC_ERASE, 24'h11_0000, 1'b0);
        frame({OP_LOCK_ONE, 24'h10_0000}, 32);
        wr(OP_SEC_ERASE, 24'h10_0000, 1'b0);
    endtask

    task automatic t_table();
        for (int i = 0; i < 13; i++) begin
            set_prot({2'b01, TBL[i][29:25]});
            wr(TBL[i][37:30], TBL[i][24:1], TBL[i][0]);
            idle();
        end
    endtask

    task automatic t_framing();
        set_prot(7'b010_0111);
        frame({8'h20, 23'h00_0000}, 31);
        chk("partial byte", {sv, sd}, 2'b01);
        wr(OP_SEC_ERASE, 24'h20_0000, 1'b1);
        frame({OP_STAT_RD, 8'h00}, 16);
        chk("status busy", rx[7:0], 8'h01);
        frame({OP_SEC_ERASE, 24'h30_0000}, 32);
        chk("busy write", {sv, sd}, 2'b01);
        idle();
    endtask

    task automatic t_ids();
        frame({OP_ID_STD, 24'h00_0000}, 32);
        chk("std id", rx[23:0], 24'h6B_1D2E);
        frame({OP_ID_LEGACY, 32'h0000_0000}, 40);
        chk("legacy id", rx[7:0], 8'h47);
        frame({OP_ID_MAKER, 40'h00_0000_0000}, 48);
        chk("maker id", rx[15:0], 16'h6B47);
        frame({OP_ID_STD, 5'h00}, 13);
        chk("cut read", {sv, sr, sd}, 3'b000);
    endtask

    task automatic conclude();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #3ms;
        error_cnt++;
        conclude();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        t_locks();
        t_table();
        t_framing();
        t_ids();
        conclude();
    end
endmodule
